// File: hdl/freeze_pkg.sv
package freeze_pkg;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFS_HOLD_EN = 12'h000;
  localparam logic [11:0] OFS_PULL_EN = 12'h004;
  localparam logic [11:0] OFS_PULL_UP = 12'h008;
  localparam logic [11:0] OFS_OUT_BUF = 12'h00C;
  localparam logic [11:0] OFS_BIDIR = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_HELD = 12'h018;
  localparam logic [11:0] OFS_ENTRY_CNT = 12'h01C;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned STAT_FROZEN_BIT = 0;
  localparam int unsigned CNT_W = 16;
  localparam logic [31:0] RST_CFG = 32'h0000_0000;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;
  localparam int unsigned PIN_MAX = 32;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic {
    ST_RUN,
    ST_FROZEN
  } freeze_state_t;

  typedef enum logic {
    DIR_IN,
    DIR_OUT
  } pin_dir_t;

endpackage

// File: hdl/freeze_ctrl.sv
`timescale 1ns/1ps
module freeze_ctrl
  import freeze_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic freeze_request_pin,
  output logic frozen,
  output logic entry_pulse
);

  freeze_state_t state_ff;
  freeze_state_t nxt_state;

  // next state of the freeze tracker
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: if (freeze_request_pin) nxt_state = ST_FROZEN;
      ST_FROZEN: if (!freeze_request_pin) nxt_state = ST_RUN;
      default: nxt_state = ST_RUN;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= ST_RUN;
    else
      state_ff <= nxt_state;
  end

  assign frozen = (state_ff == ST_FROZEN);
  assign entry_pulse = (state_ff == ST_RUN) && freeze_request_pin;

endmodule

// File: hdl/pin_cell.sv
`timescale 1ns/1ps
module pin_cell
  import freeze_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic frozen,
  input wire logic hold_en,
  input wire logic pull_en,
  input wire logic pull_up,
  input wire logic out_buf,
  input wire logic bidir,
  input wire logic core_out,
  input wire logic core_oe,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pad_pull_en,
  output logic pad_pull_up,
  output logic core_in,
  output logic held
);

  pin_dir_t dir_ff;
  logic held_ff;
  logic live_out;

  // a bidir follows its enable, otherwise the buffer kind decides
  assign live_out = bidir ? core_oe : out_buf;

  // track direction and value until freeze, then stop updating
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_ff <= DIR_IN;
      held_ff <= 1'b0;
    end
    else if (!frozen)
    begin
      dir_ff <= live_out ? DIR_OUT : DIR_IN;
      held_ff <= live_out ? core_out : pad_in;
    end
  end

  assign held = held_ff;

  // pad and core side selection
  always_comb
  begin
    pad_out = core_out;
    pad_oe = live_out;
    pad_pull_en = pull_en;
    pad_pull_up = pull_up;
    core_in = pad_in;
    if (frozen)
    begin
      pad_out = held_ff;
      pad_oe = 1'b0;
      core_in = hold_en ? held_ff : 1'b1;
      case (dir_ff)
        DIR_OUT:
          if (hold_en)
          begin
            pad_pull_en = 1'b1;
            pad_pull_up = held_ff;
          end
        DIR_IN: ;
        default: pad_pull_en = 1'b0;
      endcase
    end
  end

endmodule

// File: hdl/io_freeze_retention.sv
`timescale 1ns/1ps
module io_freeze_retention
  import freeze_pkg::*;
#(
  parameter int unsigned NUM_PINS = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic freeze_request_pin,
  output logic freeze_active,
  input wire logic [NUM_PINS-1:0] core_out,
  input wire logic [NUM_PINS-1:0] core_oe,
  output logic [NUM_PINS-1:0] core_in,
  input wire logic [NUM_PINS-1:0] pad_in,
  output logic [NUM_PINS-1:0] pad_out,
  output logic [NUM_PINS-1:0] pad_oe,
  output logic [NUM_PINS-1:0] pad_pull_en,
  output logic [NUM_PINS-1:0] pad_pull_up
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (NUM_PINS < 1 || NUM_PINS > PIN_MAX)
  begin : g_bad_width
    $error("NUM_PINS must lie between 1 and 32");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [NUM_PINS-1:0] hold_en_ff;
  logic [NUM_PINS-1:0] pull_en_ff;
  logic [NUM_PINS-1:0] pull_up_ff;
  logic [NUM_PINS-1:0] out_buf_ff;
  logic [NUM_PINS-1:0] bidir_ff;
  logic [NUM_PINS-1:0] held;
  logic [NUM_PINS-1:0] out_sel;
  logic [CNT_W-1:0] entry_cnt_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [31:0] nxt_prdata;
  logic nxt_pslverr;
  logic frz;
  logic entry_pulse;
  logic setup_phase;
  logic wr_access;

  // widen a pin vector into a bus word, upper bits zero
  function automatic logic [31:0] widen(input logic [NUM_PINS-1:0] v);
    logic [31:0] w;
    w = RST_RDATA;
    w[NUM_PINS-1:0] = v;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // freeze tracking
  // ----------------------------------------------------------------
  freeze_ctrl u_freeze_ctrl (
    .pclk(pclk),
    .presetn(presetn),
    .freeze_request_pin(freeze_request_pin),
    .frozen(frz),
    .entry_pulse(entry_pulse)
  );

  assign freeze_active = frz;

  // ----------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------
  // zero wait states: the access phase always completes at once
  assign pready = 1'b1;
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pready && pwrite;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // per-pin settings, written in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_en_ff <= RST_CFG[NUM_PINS-1:0];
      pull_en_ff <= RST_CFG[NUM_PINS-1:0];
      pull_up_ff <= RST_CFG[NUM_PINS-1:0];
      out_buf_ff <= RST_CFG[NUM_PINS-1:0];
      bidir_ff <= RST_CFG[NUM_PINS-1:0];
    end
    else if (wr_access)
    begin
      case (paddr)
        OFS_HOLD_EN: hold_en_ff <= pwdata[NUM_PINS-1:0];
        OFS_PULL_EN: pull_en_ff <= pwdata[NUM_PINS-1:0];
        OFS_PULL_UP: pull_up_ff <= pwdata[NUM_PINS-1:0];
        OFS_OUT_BUF: out_buf_ff <= pwdata[NUM_PINS-1:0];
        OFS_BIDIR: bidir_ff <= pwdata[NUM_PINS-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // freeze entry counter
  // ----------------------------------------------------------------
  // a write clears it; an entry in the same cycle still counts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      entry_cnt_ff <= RST_CNT;
    else if (wr_access && paddr == OFS_ENTRY_CNT)
      entry_cnt_ff <= entry_pulse ? CNT_W'(1) : RST_CNT;
    else if (entry_pulse)
      entry_cnt_ff <= entry_cnt_ff + CNT_W'(1);
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // decode during setup so the data sits in a flop for the access
  always_comb
  begin
    nxt_prdata = RST_RDATA;
    nxt_pslverr = 1'b0;
    case (paddr)
      OFS_HOLD_EN: nxt_prdata = widen(hold_en_ff);
      OFS_PULL_EN: nxt_prdata = widen(pull_en_ff);
      OFS_PULL_UP: nxt_prdata = widen(pull_up_ff);
      OFS_OUT_BUF: nxt_prdata = widen(out_buf_ff);
      OFS_BIDIR: nxt_prdata = widen(bidir_ff);
      OFS_STATUS: nxt_prdata[STAT_FROZEN_BIT] = frz;
      OFS_HELD: nxt_prdata = widen(held);
      OFS_ENTRY_CNT: nxt_prdata[CNT_W-1:0] = entry_cnt_ff;
      default: nxt_pslverr = 1'b1;
    endcase
    if (pwrite)
      nxt_prdata = RST_RDATA;
  end

  // read data and error flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= RST_RDATA;
      pslverr_ff <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
    else if (!psel)
    begin
      prdata_ff <= RST_RDATA;
      pslverr_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin cells
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_PINS; i++)
  begin : g_pin
    // each pin carries its own hold and pull choice
    pin_cell u_pin_cell (
      .pclk(pclk),
      .presetn(presetn),
      .frozen(frz),
      .hold_en(hold_en_ff[i]),
      .pull_en(pull_en_ff[i]),
      .pull_up(pull_up_ff[i]),
      .out_buf(out_buf_ff[i]),
      .bidir(bidir_ff[i]),
      .core_out(core_out[i]),
      .core_oe(core_oe[i]),
      .pad_in(pad_in[i]),
      .pad_out(pad_out[i]),
      .pad_oe(pad_oe[i]),
      .pad_pull_en(pad_pull_en[i]),
      .pad_pull_up(pad_pull_up[i]),
      .core_in(core_in[i]),
      .held(held[i])
    );

    // reference direction, derived apart from the cell
    assign out_sel[i] = bidir_ff[i] ? core_oe[i] : out_buf_ff[i];

    // ------------------------------------------------------------
    // checks per pin
    // ------------------------------------------------------------
    chk_out_hold_value: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(frz) && hold_en_ff[i] && $past(out_sel[i])
      |-> pad_pull_en[i] && !pad_oe[i] && pad_pull_up[i] == $past(core_out[i]))
      else $error("held output not pulled to last driven value");

    chk_in_hold_capture: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(frz) && hold_en_ff[i] && !$past(out_sel[i])
      |-> core_in[i] == $past(pad_in[i]))
      else $error("held input lost its pre-freeze value");

    chk_hold_core_steady: assert property (
      @(posedge pclk) disable iff (!presetn)
      frz && $past(frz) && hold_en_ff[i] && $stable(hold_en_ff[i])
      |-> $stable(core_in[i]))
      else $error("held core value moved while frozen");

    chk_pull_no_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      frz && !hold_en_ff[i] && pull_en_ff[i]
      |-> pad_pull_en[i] && !pad_oe[i] && pad_pull_up[i] == pull_up_ff[i])
      else $error("configured pull not applied while frozen");

    chk_hold_beats_pull: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(frz) && hold_en_ff[i] && $past(out_sel[i]) && pull_en_ff[i]
      ##1 frz && $stable(hold_en_ff[i])
      |-> pad_pull_up[i] == $past(pad_pull_up[i]) && pad_pull_en[i])
      else $error("pull setting overrode the held output level");

    chk_tristate_high: assert property (
      @(posedge pclk) disable iff (!presetn)
      frz && !hold_en_ff[i] && !pull_en_ff[i]
      |-> !pad_oe[i] && !pad_pull_en[i] && core_in[i])
      else $error("unconfigured pin not tristated with core high");

    chk_entry_value: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(frz) && hold_en_ff[i] && !$past(out_sel[i])
      ##1 frz && hold_en_ff[i] |-> core_in[i] == $past(pad_in[i], 2))
      else $error("held input differs from value at entry");

    chk_unheld_high: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(frz) && !hold_en_ff[i]
      |-> core_in[i] [*2] or (core_in[i] ##1 !frz))
      else $error("unheld input not forced high while frozen");

    chk_bidir_held_core: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(frz) && hold_en_ff[i] && bidir_ff[i] && $past(core_oe[i])
      |-> core_in[i] == $past(core_out[i]) && pad_pull_up[i] == core_in[i])
      else $error("bidir core side does not see held value");

    chk_bidir_direction: assert property (
      @(posedge pclk) disable iff (!presetn)
      !frz && bidir_ff[i] |-> pad_oe[i] == core_oe[i])
      else $error("bidir pad enable does not follow core enable");

    chk_release_normal: assert property (
      @(posedge pclk) disable iff (!presetn)
      $fell(frz) |-> core_in[i] == pad_in[i] && pad_oe[i] == out_sel[i]
      && pad_out[i] == core_out[i] && pad_pull_en[i] == pull_en_ff[i])
      else $error("pin not back to normal after freeze release");

    chk_normal_pull: assert property (
      @(posedge pclk) disable iff (!presetn)
      !frz |-> pad_pull_en[i] == pull_en_ff[i] && pad_pull_up[i] == pull_up_ff[i])
      else $error("pull setting not followed outside freeze");

    chk_track_out: assert property (
      @(posedge pclk) disable iff (!presetn)
      !frz && out_sel[i] |=> held[i] == $past(core_out[i]))
      else $error("held value not tracking the driven output");

    chk_track_in: assert property (
      @(posedge pclk) disable iff (!presetn)
      !frz && !out_sel[i] |=> held[i] == $past(pad_in[i]))
      else $error("held value not tracking the sensed pad");
  end

  // ----------------------------------------------------------------
  // checks on freeze timing, pin independence and apb errors
  // ----------------------------------------------------------------
  chk_freeze_entry: assert property (
    @(posedge pclk) disable iff (!presetn)
    freeze_request_pin && !frz |=> frz && entry_cnt_ff != $past(entry_cnt_ff))
    else $error("freeze not entered one cycle after request");

  chk_freeze_exit: assert property (
    @(posedge pclk) disable iff (!presetn)
    !freeze_request_pin && frz |=> !frz)
    else $error("freeze not left one cycle after release");

  chk_per_pin_mix: assert property (
    @(posedge pclk) disable iff (!presetn)
    frz |-> ((core_in | hold_en_ff) == {NUM_PINS{1'b1}}))
    else $error("pin without hold drove core low while frozen");

  chk_apb_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup_phase && nxt_pslverr ##1 psel && penable |-> pslverr && prdata == RST_RDATA)
    else $error("unmapped access not answered with an error");

  // ----------------------------------------------------------------
  // checks on the register side
  // ----------------------------------------------------------------
  chk_cfg_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_access && paddr == OFS_HOLD_EN |=> hold_en_ff == $past(pwdata[NUM_PINS-1:0]))
    else $error("hold setting not taken from the bus");

  chk_cnt_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_access && paddr == OFS_ENTRY_CNT
    |=> entry_cnt_ff == ($past(entry_pulse) ? CNT_W'(1) : RST_CNT))
    else $error("entry count not cleared by a write");

  chk_cnt_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    entry_pulse && !(wr_access && paddr == OFS_ENTRY_CNT)
    |=> entry_cnt_ff == $past(entry_cnt_ff) + CNT_W'(1))
    else $error("entry count did not step on freeze entry");

  chk_status_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup_phase && !pwrite && paddr == OFS_STATUS |=> prdata[STAT_FROZEN_BIT] == $past(frz))
    else $error("status read does not show the freeze state");

  chk_idle_rdata: assert property (
    @(posedge pclk) disable iff (!presetn)
    !psel |=> prdata == RST_RDATA && !pslverr)
    else $error("read data or error left standing while idle");

  chk_write_rdata: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup_phase && pwrite |=> prdata == RST_RDATA)
    else $error("write access returned read data");

endmodule

// File: verification/pad_board.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// board side of the pads
// ----------------------------------------------------------------
module pad_board #(
  parameter int unsigned N = 8
)
(
  input wire logic pclk,
  input wire logic [N-1:0] pad_out,
  input wire logic [N-1:0] pad_oe,
  input wire logic [N-1:0] pad_pull_en,
  input wire logic [N-1:0] pad_pull_up,
  input wire logic [N-1:0] drv_en,
  input wire logic [N-1:0] drv_val,
  output logic [N-1:0] pad_in
);
  logic [N-1:0] float_ff = '0;

  // a pad nobody drives or pulls wanders every cycle
  always_ff @(posedge pclk)
  begin
    float_ff <= ~float_ff;
  end

  // wired level: device drive, board drive, weak pull, else floating
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (drv_en[i])
        pad_in[i] = drv_val[i];
      else if (pad_pull_en[i])
        pad_in[i] = pad_pull_up[i];
      else
        pad_in[i] = float_ff[i];
    end
  end
endmodule

// File: verification/io_freeze_retention_tb_top.sv
`timescale 1ns/1ps
module io_freeze_retention_tb_top
  import freeze_pkg::*;
;
  // ----------------------------------------------------------------
  // pin setup: 0,1,2,7 inputs; 3,4,5 outputs; 6,7 bidir
  // ----------------------------------------------------------------
  localparam int unsigned NP = 8;
  localparam logic [7:0] HOLD = 8'hC9;
  localparam logic [7:0] PE = 8'h1C;
  localparam logic [7:0] PU = 8'h04;
  localparam logic [7:0] OB = 8'h38;
  localparam logic [7:0] BD = 8'hC0;
  localparam logic [7:0] COE = 8'h40;
  localparam logic [7:0] DIRV = (OB & ~BD) | (BD & COE);
  localparam logic [11:0] OFS [5] = '{OFS_HOLD_EN, OFS_PULL_EN, OFS_PULL_UP, OFS_OUT_BUF,
                                      OFS_BIDIR};
  localparam logic [7:0] CFG [5] = '{HOLD, PE, PU, OB, BD};
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, freeze_request_pin, freeze_active;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [NP-1:0] core_out, core_oe, core_in, pad_in, pad_out, pad_oe, pad_pull_en;
  logic [NP-1:0] pad_pull_up, drv_en, drv_val, co, dv;
  int error_cnt = 0;
  int num_checks = 0;

  io_freeze_retention #(.NUM_PINS(NP)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .freeze_request_pin, .freeze_active,
    .core_out, .core_oe, .core_in, .pad_in, .pad_out, .pad_oe, .pad_pull_en, .pad_pull_up);
  pad_board #(.N(NP)) board (.pclk, .pad_out, .pad_oe, .pad_pull_en, .pad_pull_up,
    .drv_en, .drv_val, .pad_in);

  // 40 MHz clock
  initial
  begin
    forever #12.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // report, compares and bus access
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pins(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    num_checks++;
    if ((got & m) !== (exp & m))
    begin
      error_cnt++;
      $display("[FAIL] %0t pins %b expected %b", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      $display("[FAIL] %0t no pready", $time);
      end_of_test();
    end
    else
    begin
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk_word(q, exp);
    chk_word({31'h0000_0000, e}, {31'h0000_0000, ee});
  endtask

  // frozen pads and core side against the per-pin settings
  task automatic frz_chk();
    logic [7:0] eci, epe, epu;
    for (int i = 0; i < 8; i++)
    begin
      epe[i] = PE[i];
      epu[i] = PU[i];
      eci[i] = HOLD[i] ? (DIRV[i] ? co[i] : dv[i]) : 1'b1;
      if (DIRV[i] && HOLD[i])
      begin
        epe[i] = 1'b1;
        epu[i] = co[i];
      end
    end
    chk_pins({7'h00, freeze_active}, 8'h01, 8'h01);
    chk_pins(pad_oe, 8'h00, 8'hFF);
    chk_pins(pad_pull_en, epe, 8'hFF);
    chk_pins(pad_pull_up, epu, epe);
    chk_pins(core_in, eci, 8'hFF);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] q;
    logic e;
    presetn = 1'b0;
    {psel, penable, pwrite, freeze_request_pin} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {core_out, core_oe, drv_en, drv_val} = 32'h0000_0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      rd_chk(OFS[i], RST_CFG, 1'b0);
      apb(1'b1, OFS[i], {24'hFF_FFFF, CFG[i]}, q, e);
      rd_chk(OFS[i], {24'h00_0000, CFG[i]}, 1'b0);
    end
    rd_chk(12'h020, 32'h0000_0000, 1'b1);
    $display("test config done");
    core_oe <= COE;
    drv_en <= 8'h83;
    for (int r = 0; r < 2; r++)
    begin
      @(posedge pclk);
      co = r ? 8'hB7 : 8'h48;
      dv = r ? 8'h82 : 8'h01;
      core_out <= co;
      drv_val <= dv;
      @(posedge pclk);
      freeze_request_pin <= 1'b1;
      repeat (2) @(posedge pclk);
      #1 frz_chk();
      rd_chk(OFS_STATUS, 32'h0000_0001, 1'b0);
      rd_chk(OFS_HELD, {24'h00_0000, (co & DIRV) | (dv & 8'h83) | 8'h04}, 1'b0);
      core_out <= ~co;
      drv_val <= ~dv;
      repeat (2) @(posedge pclk);
      #1 frz_chk();
      @(posedge pclk);
      drv_en <= 8'h00;
      repeat (2) @(posedge pclk);
      #1 frz_chk();
      @(posedge pclk);
      freeze_request_pin <= 1'b0;
      drv_en <= 8'h83;
      repeat (2) @(posedge pclk);
      #1 chk_pins({7'h00, freeze_active}, 8'h00, 8'h01);
      chk_pins(pad_oe, DIRV, 8'hFF);
      chk_pins(pad_out, core_out, DIRV);
      chk_pins(pad_pull_en, PE, 8'hFF);
      chk_pins(core_in, pad_in, 8'hFF);
      $display("test freeze round %0d done", r);
    end
    rd_chk(OFS_ENTRY_CNT, 32'h0000_0002, 1'b0);
    apb(1'b1, OFS_ENTRY_CNT, 32'h0000_0000, q, e);
    rd_chk(OFS_ENTRY_CNT, 32'h0000_0000, 1'b0);
    $display("test counters done");
    end_of_test();
  end
endmodule
